// File: inc/pwm_regs.svh
// Register offsets, field positions, reset values of the modulator
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH
`define PWM_BASE_HI 26'h3fffc3e
`define OFS_CONTROL 32'hffff0f80
`define OFS_A_CMP0 32'hffff0f84
`define OFS_A_CMP1 32'hffff0f88
`define OFS_A_CMP2 32'hffff0f8c
`define OFS_A_LEN 32'hffff0f90
`define OFS_B_CMP0 32'hffff0f94
`define OFS_B_CMP1 32'hffff0f98
`define OFS_B_CMP2 32'hffff0f9c
`define OFS_B_LEN 32'hffff0fa0
`define OFS_S_CMP0 32'hffff0fa4
`define OFS_S_CMP1 32'hffff0fa8
`define OFS_S_LEN 32'hffff0fac
`define OFS_IRQ_CLEAR 32'hffff0fb0
`define OFS_IRQ_STATUS 32'hffff0fb4
`define OFS_IRQ_MASK 32'hffff0fb8
`define CTRL_RESET 16'h0012
`define CTRL_BRIDGE_BIT 1
`define CTRL_DIR_BIT 2
`define CTRL_HIGH_SIDE_FORCE_OFF_BIT 4
`define CTRL_INV_ALL_BIT 5
`define CTRL_CP_LSB 6
`define CTRL_ENA_BIT 9
`define CTRL_INV1_BIT 11
`define CTRL_INV3_BIT 12
`define CFG_RESET 16'h0000
`define IRQ_BITS 3
`endif

// File: inc/pwm_pkg.sv
// Types shared by the modulator
package pwm_pkg;
  typedef struct packed {
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] len;
  } group_cfg_s;
  typedef struct packed {
    logic high_side;
    logic low_side;
  } wave_s;
endpackage

// File: rtl/pwm_block.sv
// Five-output pulse-width modulator with APB registers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "pwm_regs.svh"

module pwm_block
  import pwm_pkg::*;
#(
  parameter int TW = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic out_zero_high_side,
  output logic out_one_low_side,
  output logic out_two_high_side,
  output logic out_three_low_side,
  output logic out_four_single,
  output logic irq
);

  logic [15:0] pwm_control_r;
  group_cfg_s cfg_r [3];
  logic [TW-1:0] tmr_r [3];
  wave_s wave_r [3];
  logic [7:0] pre_r;
  logic tick;
  logic [`IRQ_BITS-1:0] irq_status_r;
  logic [`IRQ_BITS-1:0] irq_mask_r;
  logic [`IRQ_BITS-1:0] wrap_ev;
  logic [31:0] rd_nxt;
  logic hit;
  logic wr_en;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [4:0] out_r;
  logic [4:0] out_nxt;
  logic irq_r;

  // Divisor terminal count for prescale code
  function automatic logic [7:0] pre_last(input logic [2:0] cp);
    pre_last = 8'((16'h0002 << cp) - 16'h0001);
  endfunction

  // Next waveform of one group at the current timer value
  function automatic wave_s wave_step(input wave_s w, input group_cfg_s c,
                                      input logic [TW-1:0] t);
    wave_s n;
    n = w;
    if (t == c.cmp0)
      n.high_side = 1'b1;
    if (t == c.cmp1)
      n.high_side = 1'b0;
    if (t == c.len)
      n.low_side = 1'b1;
    if (t == c.cmp2 || (w.high_side && !n.high_side))
      n.low_side = 1'b0;
    wave_step = n;
  endfunction

  // Address decode inside the register window
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a[31:6] == `PWM_BASE_HI) && (a[1:0] == 2'b00);
  endfunction

  // Write strobe for one register offset
  function automatic logic wr_at(input logic [31:0] a);
    wr_at = wr_en && (paddr == a);
  endfunction

  // Timer has reached the end of its period
  function automatic logic period_end(input logic [TW-1:0] t,
                                      input logic [15:0] len);
    period_end = (t >= TW'(len));
  endfunction

  assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;

  // APB answer: one wait state, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      if (psel & penable & ~pready_r)
      begin
        pslverr_r <= ~hit;
        prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
      end
      else
        pslverr_r <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_nxt = 32'h00000000;
    hit = in_window(paddr);
    unique case (paddr)
      `OFS_CONTROL: rd_nxt = {16'h0000, pwm_control_r};
      `OFS_A_CMP0: rd_nxt = {16'h0000, cfg_r[0].cmp0};
      `OFS_A_CMP1: rd_nxt = {16'h0000, cfg_r[0].cmp1};
      `OFS_A_CMP2: rd_nxt = {16'h0000, cfg_r[0].cmp2};
      `OFS_A_LEN: rd_nxt = {16'h0000, cfg_r[0].len};
      `OFS_B_CMP0: rd_nxt = {16'h0000, cfg_r[1].cmp0};
      `OFS_B_CMP1: rd_nxt = {16'h0000, cfg_r[1].cmp1};
      `OFS_B_CMP2: rd_nxt = {16'h0000, cfg_r[1].cmp2};
      `OFS_B_LEN: rd_nxt = {16'h0000, cfg_r[1].len};
      `OFS_S_CMP0: rd_nxt = {16'h0000, cfg_r[2].cmp0};
      `OFS_S_CMP1: rd_nxt = {16'h0000, cfg_r[2].cmp1};
      `OFS_S_LEN: rd_nxt = {16'h0000, cfg_r[2].len};
      `OFS_IRQ_CLEAR: rd_nxt = 32'h00000000;
      `OFS_IRQ_STATUS: rd_nxt = {29'h00000000, irq_status_r};
      `OFS_IRQ_MASK: rd_nxt = {29'h00000000, irq_mask_r};
      default: hit = 1'b0;
    endcase
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_control_r <= `CTRL_RESET;
    else if (wr_at(`OFS_CONTROL))
      pwm_control_r <= pwdata[15:0];
  end

  // Compare and period registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int g = 0; g < 3; g++)
        cfg_r[g] <= {4{`CFG_RESET}};
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `OFS_A_CMP0: cfg_r[0].cmp0 <= pwdata[15:0];
        `OFS_A_CMP1: cfg_r[0].cmp1 <= pwdata[15:0];
        `OFS_A_CMP2: cfg_r[0].cmp2 <= pwdata[15:0];
        `OFS_A_LEN: cfg_r[0].len <= pwdata[15:0];
        `OFS_B_CMP0: cfg_r[1].cmp0 <= pwdata[15:0];
        `OFS_B_CMP1: cfg_r[1].cmp1 <= pwdata[15:0];
        `OFS_B_CMP2: cfg_r[1].cmp2 <= pwdata[15:0];
        `OFS_B_LEN: cfg_r[1].len <= pwdata[15:0];
        `OFS_S_CMP0: cfg_r[2].cmp0 <= pwdata[15:0];
        `OFS_S_CMP1: cfg_r[2].cmp1 <= pwdata[15:0];
        `OFS_S_LEN: cfg_r[2].len <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Prescaler of the user clock
  assign tick = (pre_r ==
    pre_last(pwm_control_r[`CTRL_CP_LSB+2:`CTRL_CP_LSB]));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= 8'h00;
    else if (tick ||
             pre_r > pre_last(pwm_control_r[`CTRL_CP_LSB+2:`CTRL_CP_LSB]))
      pre_r <= 8'h00;
    else
      pre_r <= pre_r + 8'h01;
  end

  // Group timers and raw waveforms
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int g = 0; g < 3; g++)
      begin
        tmr_r[g] <= '0;
        wave_r[g] <= '0;
      end
    end
    else if (tick)
    begin
      for (int g = 0; g < 3; g++)
      begin
        wave_r[g] <= wave_step(wave_r[g], cfg_r[g], tmr_r[g]);
        if (period_end(tmr_r[g], cfg_r[g].len))
          tmr_r[g] <= '0;
        else
          tmr_r[g] <= tmr_r[g] + TW'(1);
      end
    end
  end

  // One event per group at the end of its period
  always_comb
  begin
    for (int g = 0; g < 3; g++)
      wrap_ev[g] = tick && period_end(tmr_r[g], cfg_r[g].len);
  end

  // Sticky interrupt status, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_r <= '0;
    else if (wr_at(`OFS_IRQ_CLEAR))
      irq_status_r <= wrap_ev;
    else if (wr_at(`OFS_IRQ_STATUS))
      irq_status_r <= (irq_status_r & ~pwdata[`IRQ_BITS-1:0]) | wrap_ev;
    else
      irq_status_r <= irq_status_r | wrap_ev;
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_r <= '0;
    else if (wr_at(`OFS_IRQ_MASK))
      irq_mask_r <= pwdata[`IRQ_BITS-1:0];
  end

  // Level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_status_r & irq_mask_r);
  end

  // Output steering by mode
  always_comb
  begin
    out_nxt = {wave_r[2].high_side, wave_r[1].low_side, wave_r[1].high_side,
               wave_r[0].low_side, wave_r[0].high_side};
    if (pwm_control_r[`CTRL_BRIDGE_BIT])
    begin
      if (!pwm_control_r[`CTRL_ENA_BIT])
        out_nxt[3:0] = 4'h0;
      else if (pwm_control_r[`CTRL_DIR_BIT])
        out_nxt[3:2] = 2'b00;
      else
        out_nxt[1:0] = 2'b00;
    end
    out_nxt[1] = out_nxt[1] ^ pwm_control_r[`CTRL_INV1_BIT];
    out_nxt[3] = out_nxt[3] ^ pwm_control_r[`CTRL_INV3_BIT];
    if (pwm_control_r[`CTRL_INV_ALL_BIT])
      out_nxt = ~out_nxt;
    if (pwm_control_r[`CTRL_HIGH_SIDE_FORCE_OFF_BIT])
      out_nxt[3:0] = 4'b0101;
  end

  // Output register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_r <= 5'h05;
    else
      out_r <= out_nxt;
  end

  assign out_zero_high_side = out_r[0];
  assign out_one_low_side = out_r[1];
  assign out_two_high_side = out_r[2];
  assign out_three_low_side = out_r[3];
  assign out_four_single = out_r[4];
  assign irq = irq_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

endmodule

// File: dv/pwm_load.sv
// Load model that counts high cycles on each modulator output
`timescale 1ns/1ps
module pwm_load (
  input wire logic pclk,
  input wire logic clr,
  input wire logic [4:0] outs,
  output logic [4:0][15:0] hi_cnt
);
  always_ff @(posedge pclk)
    for (int i = 0; i < 5; i++)
      hi_cnt[i] <= clr ? 16'h0 : hi_cnt[i] + 16'(outs[i]);
endmodule

// File: dv/pwm_block_props.sv
// Port checker for the modulator
`timescale 1ns/1ps
`include "pwm_regs.svh"
module pwm_block_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_zero_high_side,
  input wire logic out_one_low_side,
  input wire logic out_two_high_side,
  input wire logic out_three_low_side,
  input wire logic irq
);
  logic [15:0] ctl_r;
  logic idle;
  logic [3:0] o;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign o = {out_three_low_side, out_two_high_side, out_one_low_side,
    out_zero_high_side};
  assign idle = ctl_r[1] && ctl_r[12:9] == 4'h0 && ctl_r[5:4] == 2'h0;
  // Shadow of the control register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctl_r <= `CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == `OFS_CONTROL)
      ctl_r <= pwdata[15:0];
  a_ready_time: assert property (psel && !penable |-> ##[1:3] pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_high_side_force_off_force: assert property (ctl_r[4] && $past(ctl_r[4], 3) |-> o == 4'h5)
    else $error("high side off not forced");
  a_bridge_idle: assert property (idle && $past(idle, 3) |-> o == 4'h0)
    else $error("bridge outputs not idle");
  a_irq_hold: assert property (irq && !psel && !$past(psel) |=> irq)
    else $error("irq dropped");
  cover property (pslverr);
  cover property (irq);
  cover property ($rose(out_zero_high_side));
endmodule
bind pwm_block pwm_block_props i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .out_zero_high_side(out_zero_high_side), .irq(irq),
  .out_one_low_side(out_one_low_side), .out_two_high_side(out_two_high_side),
  .out_three_low_side(out_three_low_side));

// File: dv/five_channel_pwm_hbridge_bench.sv
// Self-checking bench for the five-output modulator
`timescale 1ns/1ps
`include "pwm_regs.svh"
module five_channel_pwm_hbridge_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, irq, err;
  wire [4:0] outs;
  logic [4:0][15:0] hi_cnt;
  int n_errors = 0, n_compared = 0, t;
  int d [11] = '{2, 6, 1, 9, 3, 8, 2, 9, 4, 5, 9};
  int duty [5] = '{4, 2, 5, 3, 1};
  int ctl [3] = '{32'h206, 32'h202, 32'h1820};
  int mode_hi [3][5] = '{'{16, 8, 0, 0, 4}, '{0, 0, 20, 36, 4},
    '{24, 8, 20, 36, 36}};
  always #2 pclk = ~pclk;
  pwm_block i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .out_zero_high_side(outs[0]), .out_one_low_side(outs[1]),
    .out_two_high_side(outs[2]), .out_three_low_side(outs[3]),
    .out_four_single(outs[4]));
  pwm_load i_load (.pclk(pclk), .clr(clr), .outs(outs), .hi_cnt(hi_cnt));
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, dat);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1)
    begin
      chk("pready", 1, 0);
      end_sim;
    end
  endtask
  task automatic rchk(input string what, input logic [31:0] a, exp);
    apb(0, a, 0);
    chk(what, exp, rd);
  endtask
  task automatic pause;
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic measure(input int tk);
    repeat (12 * tk) @(posedge pclk);
    clr <= 1;
    @(posedge pclk) clr <= 0;
    repeat (20 * tk) @(posedge pclk);
    #1;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    chk("outputs", 32'h5, 32'(outs[3:0]));
    rchk("control", `OFS_CONTROL, 32'h12);
    rchk("compare", `OFS_A_CMP0, 32'h0);
    $display("reset test done");
    apb(1, 32'hffff0fbc, 32'h5);
    chk("slverr", 1, err);
    apb(1, `OFS_CONTROL, 32'hffffffff);
    rchk("control", `OFS_CONTROL, 32'hffff);
    apb(1, `OFS_CONTROL, 32'h2);
    pause;
    chk("outputs", 32'h0, 32'(outs[3:0]));
    for (int i = 0; i < 11; i++)
      apb(1, `OFS_A_CMP0 + 4 * i, d[i]);
    for (int i = 0; i < 11; i++)
      rchk("group reg", `OFS_A_CMP0 + 4 * i, d[i]);
    $display("register test done");
    for (int c = 0; c < 8; c++)
    begin
      apb(1, `OFS_CONTROL, c << 6);
      t = 2 << c;
      measure(t);
      for (int i = 0; i < 5; i++)
        chk("high cycles", 2 * duty[i] * t, 32'(hi_cnt[i]));
    end
    $display("waveform test done");
    apb(1, `OFS_B_CMP2, 32'hffff);
    for (int s = 0; s < 3; s++)
    begin
      apb(1, `OFS_CONTROL, ctl[s]);
      measure(2);
      for (int i = 0; i < 5; i++)
        chk("mode cycles", mode_hi[s][i], 32'(hi_cnt[i]));
    end
    $display("mode test done");
    apb(1, `OFS_CONTROL, 32'h10);
    pause;
    chk("outputs", 32'h5, 32'(outs[3:0]));
    $display("force test done");
    for (int i = 0; i < 3; i++)
      apb(1, `OFS_A_LEN + 16 * i - (i / 2) * 4, 32'hffff);
    apb(1, `OFS_CONTROL, 32'h1c0);
    rchk("status", `OFS_IRQ_STATUS, 32'h7);
    chk("irq", 0, irq);
    apb(1, `OFS_IRQ_MASK, 32'h7);
    pause;
    chk("irq", 1, irq);
    apb(1, `OFS_IRQ_STATUS, 32'h1);
    rchk("status", `OFS_IRQ_STATUS, 32'h6);
    apb(1, `OFS_IRQ_CLEAR, 32'h0);
    rchk("status", `OFS_IRQ_STATUS, 32'h0);
    pause;
    chk("irq", 0, irq);
    $display("interrupt test done");
    presetn <= 0;
    pause;
    chk("outputs", 32'h5, 32'(outs[3:0]));
    presetn <= 1;
    rchk("control", `OFS_CONTROL, 32'h12);
    chk("irq", 0, irq);
    $display("second reset test done");
    end_sim;
  end
endmodule
